// ---- patxd_ctrl.v ----
// Power-amp enable source select, transmit-enable override, coarse latency and PLL event enables.
`timescale 1ns/1ps
`default_nettype none
`include "patxd_defines.vh"
// What this block does
// - Protection-source bit 6 lets amp protection logic steer amp enable; resets zero.
// - Bit 5 lets transmit-enable sequencer steer amp enable; resets one.
// - Bit 4 lets blanking sequencer steer amp enable; resets zero.
// - Bit 3 makes software bit 2 drive amp enable off, or on if no other selected source requests off.
// - Bit 1 replaces transmit-enable pins with software level bit 0.
// - Four-bit coarse latency code spans -4 to +3.5 clocks, 0 minimum.
// - Latency steps in half clock periods; field resets to 0x8.
// - Unlock event enable bit 5 flags clock PLL losing lock.
// - Lock event enable bit 4 flags clock PLL reaching lock.
// - Dual-A mask with transmit-enable 0 low powers down converters 0 and 1.
module patxd_ctrl #(
    parameter NUM_TXEN = 2
) (
    // Clock and reset.
    input wire clk,
    input wire nrst,
    // Register access port.
    input wire wr_en,
    input wire rd_en,
    input wire [`PATXD_ADDR_W-1:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    output reg rd_valid,
    // Amp enable requests from internal sources, same clock.
    input wire prot_amp_req,
    input wire tx_seq_amp_req,
    input wire blank_seq_amp_req,
    // External pins and PLL lock status from outside the clock domain.
    input wire [NUM_TXEN-1:0] tx_enable_pins,
    input wire clock_pll_lock_flag,
    // Block outputs.
    output reg amp_enable,
    output reg [NUM_TXEN-1:0] transmit_enable_inputs,
    output reg [3:0] coarse_latency_code,
    output reg signed [4:0] latency_half_steps,
    output reg [1:0] dual_a_power_down,
    output reg clock_pll_unlock_event,
    output reg clock_pll_locked_event
);
    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    reg [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    reg [NUM_TXEN-1:0] pin_meta_reg;
    reg [NUM_TXEN-1:0] pin_sync_reg;
    reg lock_meta_reg;
    reg lock_sync_reg;
    reg lock_prev_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= {NUM_TXEN{1'b0}};
            pin_sync_reg <= {NUM_TXEN{1'b0}};
            lock_meta_reg <= 1'b0;
            lock_sync_reg <= 1'b0;
            lock_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= tx_enable_pins;
            pin_sync_reg <= pin_meta_reg;
            lock_meta_reg <= clock_pll_lock_flag;
            lock_sync_reg <= lock_meta_reg;
            lock_prev_reg <= lock_sync_reg;
        end
    end
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    reg [7:0] amp_ctrl_reg;
    reg [7:0] latency_reg;
    reg [7:0] pll_evt_reg;
    reg [7:0] txen_mask_reg;
    // Turns an offset into a one-hot register select; unmapped gives zero.
    function [3:0] reg_select;
        input [`PATXD_ADDR_W-1:0] ofs;
        begin
            case (ofs)
                `PATXD_OFS_TXEN_MASK: reg_select = 4'h1;
                `PATXD_OFS_AMP_CTRL: reg_select = 4'h2;
                `PATXD_OFS_LATENCY: reg_select = 4'h4;
                `PATXD_OFS_PLL_EVT: reg_select = 4'h8;
                default: reg_select = 4'h0;
            endcase
        end
    endfunction
    // A write to an unmapped offset selects nothing and is dropped.
    wire [3:0] wr_sel = wr_en ? reg_select(addr) : 4'h0;
    wire [3:0] rd_sel = reg_select(addr);
    // Reserved bits are masked on the way in, so they read zero, except in the PLL event register, whose mask keeps all eight bits.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txen_mask_reg <= `PATXD_RST_TXEN_MASK;
        end else if (wr_sel[0]) begin
            txen_mask_reg <= wr_data & `PATXD_TXEN_MASK_MASK;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_ctrl_reg <= `PATXD_RST_AMP_CTRL;
        end else if (wr_sel[1]) begin
            amp_ctrl_reg <= wr_data & `PATXD_AMP_CTRL_MASK;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latency_reg <= `PATXD_RST_LATENCY;
        end else if (wr_sel[2]) begin
            latency_reg <= wr_data & `PATXD_LATENCY_MASK;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_evt_reg <= `PATXD_RST_PLL_EVT;
        end else if (wr_sel[3]) begin
            pll_evt_reg <= wr_data & `PATXD_PLL_EVT_MASK;
        end
    end
    // Reads answer one cycle later; unmapped offsets read as zero.
    reg [7:0] rd_next;
    always @* begin
        case (rd_sel)
            4'h1: rd_next = txen_mask_reg;
            4'h2: rd_next = amp_ctrl_reg;
            4'h4: rd_next = latency_reg;
            4'h8: rd_next = pll_evt_reg;
            default: rd_next = 8'h00;
        endcase
    end
    // ------------------------------------------------------------
    // Amp enable combination and transmit-enable selection
    // ------------------------------------------------------------
    wire sel_prot = amp_ctrl_reg[`PATXD_BIT_FROM_PROT];
    wire sel_txseq = amp_ctrl_reg[`PATXD_BIT_FROM_TXSEQ];
    wire sel_blank = amp_ctrl_reg[`PATXD_BIT_FROM_BLANK];
    wire sel_sw = amp_ctrl_reg[`PATXD_BIT_FROM_SW];
    wire sw_on = amp_ctrl_reg[`PATXD_BIT_SW_ON_OFF];
    wire sw_tx_ovr = amp_ctrl_reg[`PATXD_BIT_SW_TX_OVR];
    wire sw_tx_lvl = amp_ctrl_reg[`PATXD_BIT_SW_TX_LVL];
    // A selected source that requests off wins; with none selected the amp
    // stays off, so a cleared select field cannot leave the amp running.
    wire any_sel = sel_prot | sel_txseq | sel_blank | sel_sw;
    wire amp_next = any_sel
        & (~sel_prot | prot_amp_req)
        & (~sel_txseq | tx_seq_amp_req)
        & (~sel_blank | blank_seq_amp_req)
        & (~sel_sw | sw_on);
    wire [NUM_TXEN-1:0] txen_next = sw_tx_ovr ?
        {NUM_TXEN{sw_tx_lvl}} : pin_sync_reg;
    wire dual_a_off = txen_mask_reg[`PATXD_BIT_DUAL_A_MASK] & ~txen_next[0];
    // Code 8 is zero offset; each code step is half a converter clock.
    wire [4:0] half_raw = {1'b0, latency_reg[3:0]} - `PATXD_LAT_ZERO_CODE;
    wire signed [4:0] half_next = $signed(half_raw);
    // Lock edges are taken from the synchronised copy only.
    wire unlock_seen = lock_prev_reg & ~lock_sync_reg;
    wire lock_seen = ~lock_prev_reg & lock_sync_reg;
    // ------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_data <= rd_en ? rd_next : 8'h00;
            rd_valid <= rd_en;
        end
    end
    // ------------------------------------------------------------
    // Amp enable, transmit-enable and power-down outputs
    // ------------------------------------------------------------
    // The pins reach these outputs three edges after they change.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_enable <= 1'b0;
            transmit_enable_inputs <= {NUM_TXEN{1'b0}};
            dual_a_power_down <= 2'h0;
        end else begin
            amp_enable <= amp_next;
            transmit_enable_inputs <= txen_next;
            dual_a_power_down <= {2{dual_a_off}};
        end
    end
    // ------------------------------------------------------------
    // Coarse latency outputs
    // ------------------------------------------------------------
    // Code 0 gives minus eight half steps and code 15 plus seven.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coarse_latency_code <= `PATXD_RST_LAT_CODE;
            latency_half_steps <= 5'h00;
        end else begin
            coarse_latency_code <= latency_reg[3:0];
            latency_half_steps <= half_next;
        end
    end
    // ------------------------------------------------------------
    // Clock PLL lock events
    // ------------------------------------------------------------
    // Each event is a one-cycle pulse, enabled per direction.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_pll_unlock_event <= 1'b0;
            clock_pll_locked_event <= 1'b0;
        end else begin
            clock_pll_unlock_event <= pll_evt_reg[`PATXD_BIT_UNLOCK_EN]
                & unlock_seen;
            clock_pll_locked_event <= pll_evt_reg[`PATXD_BIT_LOCK_EN]
                & lock_seen;
        end
    end
endmodule // patxd_ctrl
`default_nettype wire

// ---- patxd_ctrl_sva.sv ----
// Assertion checker for the amp and transmit-enable control bank.
`timescale 1ns/1ps
`default_nettype none
module patxd_ctrl_chk (
    // Clock, reset and read port.
    input wire logic clk,
    input wire logic nrst,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    // Block outputs and lock status.
    input wire logic clock_pll_lock_flag,
    input wire logic [3:0] coarse_latency_code,
    input wire logic signed [4:0] latency_half_steps,
    input wire logic [1:0] dual_a_power_down,
    input wire logic [1:0] transmit_enable_inputs,
    input wire logic clock_pll_unlock_event,
    input wire logic clock_pll_locked_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rv; rd_en |=> rd_valid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_rv0; !rd_en |=> !rd_valid; endproperty
    a_rv0: assert property (p_rv0) else $error("stray read valid");
    property p_rd0; !rd_valid |-> rd_data == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("read data not idle");
    property p_lat;
        $stable(coarse_latency_code) |->
            $unsigned(latency_half_steps) == 5'(coarse_latency_code + 5'h18);
    endproperty
    a_lat: assert property (p_lat) else $error("half steps wrong");
    property p_lk;
        clock_pll_locked_event |->
            $past(clock_pll_lock_flag, 3) && !$past(clock_pll_lock_flag, 4);
    endproperty
    a_lk: assert property (p_lk) else $error("lock event unlocked");
    property p_ul;
        clock_pll_unlock_event |->
            !$past(clock_pll_lock_flag, 3) && $past(clock_pll_lock_flag, 4);
    endproperty
    a_ul: assert property (p_ul) else $error("unlock event locked");
    property p_lkp; clock_pll_locked_event |=> !clock_pll_locked_event;
    endproperty
    a_lkp: assert property (p_lkp) else $error("lock event too long");
    property p_dap; dual_a_power_down[0] == dual_a_power_down[1]; endproperty
    a_dap: assert property (p_dap) else $error("pair split");
    property p_dak; dual_a_power_down[0] |-> !transmit_enable_inputs[0];
    endproperty
    a_dak: assert property (p_dak) else $error("down with tx on");
    c_dap: cover property (dual_a_power_down[0]);
    c_rd: cover property (rd_valid);
    c_lk: cover property (clock_pll_locked_event);
    c_ul: cover property (clock_pll_unlock_event);
endmodule // patxd_ctrl_chk
bind patxd_ctrl patxd_ctrl_chk u_chk (.clk, .nrst, .rd_en, .rd_data,
    .rd_valid, .clock_pll_lock_flag, .coarse_latency_code,
    .latency_half_steps, .dual_a_power_down, .transmit_enable_inputs,
    .clock_pll_unlock_event,
    .clock_pll_locked_event);
`default_nettype wire

// ---- patxd_defines.vh ----
// Register offsets, field positions, reset values and timing for the amp/tx control bank.
`ifndef PATXD_DEFINES_VH
`define PATXD_DEFINES_VH
`define PATXD_ADDR_W 10
`define PATXD_OFS_AMP_CTRL 10'h013
`define PATXD_OFS_LATENCY 10'h014
`define PATXD_OFS_PLL_EVT 10'h01F
`define PATXD_OFS_TXEN_MASK 10'h012
`define PATXD_BIT_FROM_PROT 6
`define PATXD_BIT_FROM_TXSEQ 5
`define PATXD_BIT_FROM_BLANK 4
`define PATXD_BIT_FROM_SW 3
`define PATXD_BIT_SW_ON_OFF 2
`define PATXD_BIT_SW_TX_OVR 1
`define PATXD_BIT_SW_TX_LVL 0
`define PATXD_BIT_UNLOCK_EN 5
`define PATXD_BIT_LOCK_EN 4
`define PATXD_BIT_DUAL_A_MASK 6
`define PATXD_RST_AMP_CTRL 8'h20
`define PATXD_RST_LATENCY 8'h08
`define PATXD_RST_PLL_EVT 8'h00
`define PATXD_RST_TXEN_MASK 8'h00
`define PATXD_AMP_CTRL_MASK 8'h7F
`define PATXD_LATENCY_MASK 8'h0F
`define PATXD_PLL_EVT_MASK 8'hFF
`define PATXD_TXEN_MASK_MASK 8'hC0
`define PATXD_LAT_ZERO_CODE 5'h08
`define PATXD_RST_LAT_CODE 4'h8
`endif

// ---- tb_top.sv ----
// Self-checking testbench for the amp and transmit-enable control bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0;
    logic prot_amp_req = 1'h0, tx_seq_amp_req = 1'h0;
    logic blank_seq_amp_req = 1'h0, clock_pll_lock_flag = 1'h0;
    logic [9:0] addr = 10'h000;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic [1:0] tx_enable_pins = 2'h0, transmit_enable_inputs;
    logic rd_valid, amp_enable, clock_pll_unlock_event, clock_pll_locked_event;
    logic [1:0] dual_a_power_down;
    logic [3:0] coarse_latency_code;
    logic signed [4:0] latency_half_steps;
    int failures = 0, checked = 0;
    logic [9:0] ofs [4] = '{10'h012, 10'h013, 10'h014, 10'h01F};
    logic [7:0] rst [4] = '{8'h00, 8'h20, 8'h08, 8'h00};
    logic [7:0] msk [4] = '{8'hC0, 8'h7F, 8'h0F, 8'hFF};
    logic [3:0] lat_c [3] = '{4'h0, 4'h7, 4'hF};
    logic [11:0] amp_t [10] = '{12'h00E, 12'h409, 12'h406, 12'h205, 12'h20A,
        12'h103, 12'h10C, 12'h0C1, 12'h08E, 12'h6C8};
    patxd_ctrl dut (.clk, .nrst, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
        .rd_valid, .prot_amp_req, .tx_seq_amp_req, .blank_seq_amp_req,
        .tx_enable_pins, .clock_pll_lock_flag, .amp_enable,
        .transmit_enable_inputs, .coarse_latency_code, .latency_half_steps,
        .dual_a_power_down, .clock_pll_unlock_event, .clock_pll_locked_event);
    always #20 clk = ~clk;
    task chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr_en, addr, wr_data} <= {1'h1, a, d};
        @(posedge clk);
        wr_en <= 1'h0;
    endtask
    task rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        {rd_en, addr} <= {1'h1, a};
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, e);
    endtask
    task settle;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task pll(input logic v, input logic [1:0] e);
        logic [1:0] n;
        n = 2'h0;
        @(posedge clk);
        clock_pll_lock_flag <= v;
        repeat (8) begin
            @(posedge clk);
            #1;
            n = n | {clock_pll_locked_event, clock_pll_unlock_event};
        end
        chk({6'h00, n}, {6'h00, e});
    endtask
    task conclude;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        foreach (ofs[i]) begin
            wr(ofs[i], 8'hFF);
            rd(ofs[i], msk[i]);
        end
        wr(10'h015, 8'hFF);
        rd(10'h015, 8'h00);
        foreach (lat_c[i]) begin
            wr(10'h014, {4'h0, lat_c[i]});
            settle();
            chk({4'h0, coarse_latency_code}, {4'h0, lat_c[i]});
            chk({3'h0, latency_half_steps}, {3'h0, lat_c[i] + 5'h18});
        end
        foreach (amp_t[i]) begin
            @(posedge clk);
            {prot_amp_req, tx_seq_amp_req, blank_seq_amp_req} <= amp_t[i][3:1];
            wr(10'h013, amp_t[i][11:4]);
            settle();
            chk({7'h00, amp_enable}, {7'h00, amp_t[i][0]});
        end
        wr(10'h013, 8'h03);
        settle();
        chk({6'h00, transmit_enable_inputs}, 8'h03);
        wr(10'h013, 8'h00);
        wr(10'h012, 8'h40);
        tx_enable_pins <= 2'h2;
        settle();
        chk({6'h00, transmit_enable_inputs}, 8'h02);
        chk({6'h00, dual_a_power_down}, 8'h03);
        wr(10'h013, 8'h02);
        tx_enable_pins <= 2'h1;
        settle();
        chk({6'h00, transmit_enable_inputs}, 8'h00);
        chk({6'h00, dual_a_power_down}, 8'h03);
        wr(10'h013, 8'h00);
        settle();
        chk({6'h00, transmit_enable_inputs}, 8'h01);
        chk({6'h00, dual_a_power_down}, 8'h00);
        wr(10'h01F, 8'h30);
        pll(1'h1, 2'h2);
        pll(1'h0, 2'h1);
        wr(10'h01F, 8'h00);
        pll(1'h1, 2'h0);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
